//--- acia_params.svh
// Purpose: Offsets, field positions, reset values and bit-timing counts
// Assumes: 16 ticks of the 16x clock per bit
// Notes: Definitions only
`ifndef ACIA_PARAMS_SVH
`define ACIA_PARAMS_SVH
// ==========================================
// Register selects and reset values
`define RS_DATA 2'h0
`define RS_STAT 2'h1
`define RS_CMD 2'h2
`define RS_CTRL 2'h3
`define CMD_RST 8'h00
`define CTRL_RST 8'h00
// ==========================================
// Command and control fields
`define CMD_EN 0
`define CMD_RXI_OFF 1
`define CMD_TXC 3:2
`define CMD_ECHO 4
`define CMD_PEN 5
`define CMD_PTY 7:6
`define CTRL_BAUD 3:0
`define CTRL_RXSRC 4
`define CTRL_WLEN 6:5
`define CTRL_STOP 7
`define TXC_OFF 2'h0
`define TXC_IRQ 2'h1
`define TXC_BRK 2'h3
`define WLEN_5 2'h3
`define WLEN_8 2'h0
// ==========================================
// Tick and bit counts (last index of each span)
`define TX_BIT_LAST 6'h0f
`define TX_STOP15_LAST 6'h17
`define TX_STOP2_LAST 6'h1f
`define RX_HALF_LAST 5'h07
`define RX_BIT_LAST 5'h0f
`define RX_LONG_LAST 5'h1b
`define BITS_LAST 3'h7
`endif

//--- acia_pkg.sv
// Purpose: Types shared by the adapter modules
// Assumes: Nothing
// Notes: Gray codes along the frame path
package acia_pkg;
   typedef enum logic [2:0] {
      TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
      TX_PAR = 3'h2, TX_STOP = 3'h6, TX_BRK = 3'h7
   } tx_state_t;
   typedef enum logic [2:0] {
      RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
      RX_PAR = 3'h2, RX_STOP = 3'h6, RX_BRK = 3'h7
   } rx_state_t;
   typedef struct packed {
      logic [23:0] cnt;
      logic ext_q, rxc_q, tx_tick, rx_tick, rxc_out;
   } baud_state_t;
   typedef struct packed {
      rx_state_t st;
      logic [4:0] tcnt;
      logic [2:0] bcnt;
      logic [7:0] sh, data;
      logic par, zero, done, start, pe, fe;
   } rx_core_t;
   typedef struct packed {
      logic [7:0] cmd, ctrl, tdr, rdr, tsh, echo_sh, dout;
      logic tdr_full, receive_data_full, pe, fe, ovr, irq, dcd, dsr, mfrz;
      logic tpar, echo_blk, echo_arm;
      tx_state_t txs;
      logic [5:0] tcnt;
      logic [2:0] bcnt;
      logic doe_n, irq_n, txd, rts_n, dtr_n, rxc_oe_n;
   } main_state_t;
endpackage

//--- acia_rx_if.sv
// Purpose: Link between the register core and the receiver
// Assumes: One clock domain
// Notes: done and start are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface acia_rx_if;
   logic tick, rxd, en, pen, stop2, done, start, pe, fe;
   logic [1:0] wlen, ptype;
   logic [7:0] data;
   modport core(input tick, rxd, en, pen, stop2, wlen, ptype,
                output done, start, pe, fe, data);
   modport ctl(output tick, rxd, en, pen, stop2, wlen, ptype,
               input done, start, pe, fe, data);
endinterface
`default_nettype wire

//--- acia_baud.sv
// Purpose: 16x tick generation for transmitter and receiver
// Assumes: Crystal and receive clock pins synchronous to sys_clk_i
// Notes: Divisor ladder is BASE_DIV scaled by powers of two
`timescale 1ns/1ps
`default_nettype none
module acia_baud #(
   parameter logic [7:0] BASE_DIV = 8'h06
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic [3:0] sel_i,
   input wire logic rx_src_i,
   input wire logic xtal_clk_i,
   input wire logic rxc_i,
   output logic tx_tick_o,
   output logic rx_tick_o,
   output logic rxc_o
);
   import acia_pkg::*;
   baud_state_t q, nx;
   logic [23:0] period;

   always_comb begin
      nx = q;
      period = {16'h0000, BASE_DIV} << (4'hf - sel_i);
      nx.ext_q = xtal_clk_i;
      nx.rxc_q = rxc_i;
      nx.tx_tick = 1'b0;
      // Zero selects the crystal pin as a raw 16x clock
      if (sel_i == 4'h0) begin
         nx.tx_tick = xtal_clk_i && !q.ext_q;
      end else if (q.cnt == 24'h000000) begin
         nx.tx_tick = 1'b1;
         nx.cnt = period - 24'h000001;
      end else begin
         nx.cnt = q.cnt - 24'h000001;
      end
      nx.rx_tick = rx_src_i ? nx.tx_tick : (rxc_i && !q.rxc_q);
      nx.rxc_out = nx.tx_tick;
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
      end else begin
         q <= nx;
      end
   end

   assign tx_tick_o = q.tx_tick;
   assign rx_tick_o = q.rx_tick;
   assign rxc_o = q.rxc_out;
endmodule // acia_baud
`default_nettype wire

//--- acia_rx.sv
// Purpose: Serial receiver on the 16x receive tick
// Assumes: rxd already synchronous
// Notes: A start bit is confirmed at its middle
`timescale 1ns/1ps
`default_nettype none
`include "acia_params.svh"
module acia_rx (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   acia_rx_if.core rx
);
   import acia_pkg::*;
   rx_core_t q, nx;
   logic [2:0] nlast;
   logic long_stop;

   always_comb begin
      nx = q;
      nx.done = 1'b0;
      nx.start = 1'b0;
      nlast = `BITS_LAST - {1'b0, rx.wlen};
      long_stop = rx.stop2 && rx.wlen == `WLEN_5 && !rx.pen;
      if (rx.tick) begin
         nx.tcnt = q.tcnt + 5'h01;
         unique case (q.st)
            RX_IDLE: begin
               nx.tcnt = 5'h00;
               if (rx.en && !rx.rxd) nx.st = RX_START;
            end
            RX_START: if (q.tcnt == `RX_HALF_LAST) begin
               // A glitch shorter than half a bit is not a start
               nx.tcnt = 5'h00;
               nx.bcnt = 3'h0;
               nx.par = 1'b0;
               nx.zero = 1'b1;
               nx.start = !rx.rxd;
               nx.st = rx.rxd ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (q.tcnt == `RX_BIT_LAST) begin
               nx.tcnt = 5'h00;
               nx.sh = {rx.rxd, q.sh[7:1]};
               nx.par = q.par ^ rx.rxd;
               nx.zero = q.zero && !rx.rxd;
               nx.bcnt = q.bcnt + 3'h1;
               if (q.bcnt == nlast) nx.st = rx.pen ? RX_PAR : RX_STOP;
            end
            RX_PAR: if (q.tcnt == `RX_BIT_LAST) begin
               nx.tcnt = 5'h00;
               nx.par = q.par ^ rx.rxd;
               nx.zero = q.zero && !rx.rxd;
               nx.st = RX_STOP;
            end
            RX_STOP: begin
               if (q.tcnt == `RX_BIT_LAST) nx.fe = !rx.rxd;
               // Word completes mid stop bit, or mid trailing half bit
               if (q.tcnt == (long_stop ? `RX_LONG_LAST : `RX_BIT_LAST)) begin
                  nx.done = 1'b1;
                  nx.data = q.sh >> rx.wlen;
                  nx.pe = rx.pen && !rx.ptype[1] && (q.par == rx.ptype[0]);
                  nx.st = (q.zero && nx.fe) ? RX_BRK : RX_IDLE;
               end
            end
            RX_BRK: begin
               nx.tcnt = 5'h00;
               if (rx.rxd) nx.st = RX_IDLE;
            end
            default: nx.st = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
      end else begin
         q <= nx;
      end
   end

   assign rx.done = q.done;
   assign rx.start = q.start;
   assign rx.data = q.data;
   assign rx.pe = q.pe;
   assign rx.fe = q.fe;
endmodule // acia_rx
`default_nettype wire

//--- acia_txrx.sv
// Purpose: Asynchronous adapter transmitter, receiver and register core
// Assumes: cs_i is high for exactly one clock per processor access
// Notes: VARIANT_A selects the clear-to-send behaviour of the A part
`timescale 1ns/1ps
`default_nettype none
`include "acia_params.svh"
module acia_txrx #(
   parameter bit VARIANT_A = 1'b0,
   parameter logic [7:0] BASE_DIV = 8'h06
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic cs_i,
   input wire logic rw_i,
   input wire logic [1:0] rs_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe_n_o,
   output logic irq_n_o,
   output logic txd_o,
   input wire logic rxd_i,
   input wire logic cts_n_i,
   output logic rts_n_o,
   output logic dtr_n_o,
   input wire logic dcd_n_i,
   input wire logic dsr_n_i,
   input wire logic xtal_clk_i,
   input wire logic rxc_i,
   output logic rxc_o,
   output logic rxc_oe_n_o
);
   import acia_pkg::*;

   localparam main_state_t RST = '{
      txs: TX_IDLE, cmd: `CMD_RST, ctrl: `CTRL_RST, echo_sh: 8'hff,
      doe_n: 1'b1, irq_n: 1'b1, txd: 1'b1, rts_n: 1'b1, dtr_n: 1'b1,
      rxc_oe_n: 1'b1, default: '0};

   main_state_t q, nx;
   acia_rx_if rxi ();
   logic tx_tick, rx_tick;
   logic cts_hi, base_cts, brk_req, go, load, fin, tx_evt, line, pbit;
   logic [2:0] tlast;
   logic [5:0] stop_last;
   logic [7:0] status;

   // ==========================================
   // Clocks and receiver
   acia_baud #(.BASE_DIV(BASE_DIV)) u_baud (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .sel_i(q.ctrl[`CTRL_BAUD]),
      .rx_src_i(q.ctrl[`CTRL_RXSRC]),
      .xtal_clk_i(xtal_clk_i),
      .rxc_i(rxc_i),
      .tx_tick_o(tx_tick),
      .rx_tick_o(rx_tick),
      .rxc_o(rxc_o)
   );

   assign rxi.tick = rx_tick;
   assign rxi.rxd = rxd_i;
   assign rxi.en = q.cmd[`CMD_EN];
   assign rxi.pen = q.cmd[`CMD_PEN];
   assign rxi.ptype = q.cmd[`CMD_PTY];
   assign rxi.wlen = q.ctrl[`CTRL_WLEN];
   assign rxi.stop2 = q.ctrl[`CTRL_STOP];

   acia_rx u_rx (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .rx(rxi)
   );

   // ==========================================
   // Next state
   always_comb begin
      nx = q;
      cts_hi = cts_n_i;
      base_cts = !VARIANT_A && cts_hi;
      brk_req = q.cmd[`CMD_TXC] == `TXC_BRK;
      tlast = `BITS_LAST - {1'b0, q.ctrl[`CTRL_WLEN]};
      // Base part keeps framing while blocked so interrupts keep pace
      load = q.tdr_full && !cts_hi;
      go = load || (base_cts && q.cmd[`CMD_EN]);
      fin = 1'b0;
      tx_evt = 1'b0;
      pbit = q.cmd[7] ? !q.cmd[6] : (q.tpar ^ !q.cmd[6]);
      if (!q.ctrl[`CTRL_STOP]) begin
         stop_last = `TX_BIT_LAST;
      end else if (q.ctrl[`CTRL_WLEN] == `WLEN_5 && !q.cmd[`CMD_PEN]) begin
         stop_last = `TX_STOP15_LAST;
      end else if (q.ctrl[`CTRL_WLEN] == `WLEN_8 && q.cmd[`CMD_PEN]) begin
         stop_last = `TX_BIT_LAST;
      end else begin
         stop_last = `TX_STOP2_LAST;
      end
      status = {q.irq, q.dsr, q.dcd, !q.tdr_full && !base_cts,
                q.receive_data_full, q.ovr, q.fe, q.pe};

      // Reads and their side effects; sets further down win
      nx.doe_n = 1'b1;
      if (cs_i && rw_i) begin
         nx.doe_n = 1'b0;
         unique case (rs_i)
            `RS_DATA: begin
               nx.dout = q.rdr;
               nx.receive_data_full = 1'b0;
               nx.ovr = 1'b0;
               if (q.echo_blk) nx.echo_arm = 1'b1;
            end
            `RS_STAT: begin
               nx.dout = status;
               nx.irq = 1'b0;
               nx.mfrz = 1'b0;
            end
            `RS_CMD: nx.dout = q.cmd;
            `RS_CTRL: nx.dout = q.ctrl;
         endcase
      end

      // Transmitter, one step per 16x tick
      if (tx_tick) begin
         nx.tcnt = q.tcnt + 6'h01;
         unique case (q.txs)
            TX_IDLE: nx.tcnt = 6'h00;
            TX_START: if (q.tcnt == `TX_BIT_LAST) begin
               nx.tcnt = 6'h00;
               nx.bcnt = 3'h0;
               nx.txs = TX_DATA;
            end
            TX_DATA: if (q.tcnt == `TX_BIT_LAST) begin
               nx.tcnt = 6'h00;
               nx.tsh = {1'b1, q.tsh[7:1]};
               nx.tpar = q.tpar ^ q.tsh[0];
               nx.bcnt = q.bcnt + 3'h1;
               if (q.bcnt == tlast) nx.txs = q.cmd[`CMD_PEN] ? TX_PAR : TX_STOP;
            end
            TX_PAR: if (q.tcnt == `TX_BIT_LAST) begin
               nx.tcnt = 6'h00;
               nx.txs = TX_STOP;
            end
            TX_STOP: fin = q.tcnt == stop_last;
            TX_BRK: begin
               nx.tcnt = 6'h00;
               if (!brk_req) nx.txs = TX_STOP;
            end
            default: nx.txs = TX_IDLE;
         endcase
         // Next frame follows the stop bit directly when data is waiting
         if (fin || q.txs == TX_IDLE) begin
            nx.tcnt = 6'h00;
            if (brk_req && !q.tdr_full) begin
               nx.txs = TX_BRK;
            end else if (go) begin
               nx.txs = TX_START;
               nx.tpar = 1'b0;
               tx_evt = 1'b1;
               nx.tsh = load ? q.tdr : 8'hff;
               if (load) nx.tdr_full = 1'b0;
            end else begin
               nx.txs = TX_IDLE;
            end
         end
      end
      if (tx_evt && q.cmd[`CMD_EN] && q.cmd[`CMD_TXC] == `TXC_IRQ) nx.irq = 1'b1;

      // Writes
      if (cs_i && !rw_i) begin
         unique case (rs_i)
            `RS_DATA: begin
               nx.tdr = data_i;
               nx.tdr_full = 1'b1;
            end
            `RS_STAT: nx.tdr = q.tdr;
            `RS_CMD: nx.cmd = data_i;
            `RS_CTRL: nx.ctrl = data_i;
         endcase
      end

      // Receive completion
      if (rxi.start && q.echo_arm) begin
         nx.echo_blk = 1'b0;
         nx.echo_arm = 1'b0;
      end
      if (rxi.done) begin
         nx.pe = rxi.pe;
         nx.fe = rxi.fe;
         if (nx.receive_data_full) begin
            nx.ovr = 1'b1;
            if (q.cmd[`CMD_ECHO]) begin
               nx.echo_blk = 1'b1;
               nx.echo_arm = 1'b0;
            end
         end else begin
            nx.rdr = rxi.data;
            nx.receive_data_full = 1'b1;
         end
         if (q.cmd[`CMD_EN] && !q.cmd[`CMD_RXI_OFF]) nx.irq = 1'b1;
      end

      // Modem lines: one interrupt per change until status is read
      if (!nx.mfrz && {!dcd_n_i, !dsr_n_i} != {q.dcd, q.dsr}) begin
         nx.dcd = !dcd_n_i;
         nx.dsr = !dsr_n_i;
         if (q.cmd[`CMD_EN]) begin
            nx.irq = 1'b1;
            nx.mfrz = 1'b1;
         end
      end

      // Half-bit echo delay line on the receive tick
      if (rx_tick) nx.echo_sh = {q.echo_sh[6:0], rxd_i};

      unique case (q.txs)
         TX_START: line = 1'b0;
         TX_DATA: line = q.tsh[0];
         TX_PAR: line = pbit;
         TX_BRK: line = 1'b0;
         default: line = 1'b1;
      endcase
      // Echo is gated by clear-to-send in both parts; overrun holds it at mark
      if (q.cmd[`CMD_ECHO]) begin
         nx.txd = cts_hi || q.echo_blk || q.echo_sh[7];
      end else begin
         nx.txd = base_cts || line;
      end
      nx.irq_n = !nx.irq;
      nx.rts_n = !(nx.cmd[`CMD_TXC] != `TXC_OFF || nx.cmd[`CMD_ECHO]);
      nx.dtr_n = !nx.cmd[`CMD_EN];
      nx.rxc_oe_n = !nx.ctrl[`CTRL_RXSRC];
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= RST;
      end else begin
         q <= nx;
      end
   end

   // ==========================================
   // Pins, all from flip-flops
   assign data_o = q.dout;
   assign data_oe_n_o = q.doe_n;
   assign irq_n_o = q.irq_n;
   assign txd_o = q.txd;
   assign rts_n_o = q.rts_n;
   assign dtr_n_o = q.dtr_n;
   assign rxc_oe_n_o = q.rxc_oe_n;
endmodule // acia_txrx
`default_nettype wire

//--- acia_txrx_chk.sv
// Purpose: Port-level assertions for the adapter top
// Assumes: One clock domain, reset active low
// Notes: Bound to every acia_txrx instance
`timescale 1ns/1ps
`default_nettype none
`include "acia_params.svh"
module acia_txrx_chk #(
   parameter bit VARIANT_A = 1'b0,
   parameter logic [7:0] BASE_DIV = 8'h06
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic cs_i,
   input wire logic rw_i,
   input wire logic [1:0] rs_i,
   input wire logic [7:0] data_i,
   input wire logic [7:0] data_o,
   input wire logic data_oe_n_o,
   input wire logic irq_n_o,
   input wire logic txd_o,
   input wire logic rxd_i,
   input wire logic cts_n_i,
   input wire logic rts_n_o,
   input wire logic dtr_n_o,
   input wire logic dcd_n_i,
   input wire logic dsr_n_i,
   input wire logic xtal_clk_i,
   input wire logic rxc_i,
   input wire logic rxc_o,
   input wire logic rxc_oe_n_o
);
   // ==========================================
   // Bus and modem-line relations
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic stat_rd;
   assign stat_rd = cs_i && rw_i && (rs_i == `RS_STAT);
   sequence rd_s; cs_i && rw_i; endsequence
   sequence cmd_wr_s; cs_i && !rw_i && (rs_i == `RS_CMD); endsequence
   sequence ctrl_wr_s; cs_i && !rw_i && (rs_i == `RS_CTRL); endsequence
   sequence cts_hi_s; cts_n_i ##1 cts_n_i; endsequence
   drive_on_read_a: assert property (rd_s |=> !data_oe_n_o)
      else $error("bus not driven after read");
   drive_idle_a: assert property (!(cs_i && rw_i) |=> data_oe_n_o)
      else $error("bus driven without read");
   ready_level_a: assert property (cmd_wr_s |-> ##2 dtr_n_o == !$past(data_i[`CMD_EN], 2))
      else $error("terminal ready level wrong");
   rts_level_a: assert property (cmd_wr_s |-> ##2
      rts_n_o == ($past(data_i[`CMD_TXC], 2) == `TXC_OFF && !$past(data_i[`CMD_ECHO], 2)))
      else $error("request to send level wrong");
   clk_pin_dir_a: assert property (ctrl_wr_s |-> ##2 rxc_oe_n_o == !$past(data_i[`CTRL_RXSRC], 2))
      else $error("clock pin direction wrong");
   cts_mark_a: assert property (((!VARIANT_A) throughout cts_hi_s) |=> txd_o)
      else $error("line not mark with clear-to-send high");
   irq_enable_a: assert property ($fell(irq_n_o) |-> !dtr_n_o || !$past(dtr_n_o) || !$past(dtr_n_o, 2))
      else $error("interrupt while disabled");
   irq_clear_a: assert property ($rose(irq_n_o) |-> $past(stat_rd) || $past(stat_rd, 2))
      else $error("interrupt released without status read");
endmodule // acia_txrx_chk
bind acia_txrx acia_txrx_chk #(.VARIANT_A(VARIANT_A), .BASE_DIV(BASE_DIV)) i_acia_txrx_chk (.*);
`default_nettype wire

//--- modem_model.sv
// Purpose: Far-end serial line model
// Assumes: 16 system clocks per bit
// Notes: Line idles at mark between frames
`timescale 1ns/1ps
`default_nettype none
module modem_model (
   input wire logic sys_clk_i,
   input wire logic txd_i,
   output logic rxd_o
);
   // ==========================================
   // Frame send and capture
   initial rxd_o = 1'b1;
   task hold(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   // Stop level low makes a framing fault on purpose
   task send(input logic [7:0] d, input logic stop);
      int i;
      rxd_o = 1'b0;
      hold(16);
      for (i = 0; i < 8; i++) begin
         rxd_o = d[i];
         hold(16);
      end
      rxd_o = stop;
      hold(16);
      rxd_o = 1'b1;
      hold(16);
   endtask
   task grab(input int nb, output logic [8:0] d, output logic ok);
      int i;
      ok = 1'b0;
      d = 9'h000;
      // Line is looked at just after each edge, once the launched value has settled
      for (i = 0; i < 3000 && txd_i !== 1'b0; i++) hold(1);
      if (txd_i === 1'b0) begin
         ok = 1'b1;
         hold(8);
         for (i = 0; i < nb; i++) begin
            hold(16);
            d[i] = txd_i;
         end
      end
   endtask
endmodule // modem_model
`default_nettype wire

//--- acia_txrx_tb.sv
// Purpose: Self-checking bench for the adapter
// Assumes: BASE_DIV 1 and rate select 15 give 16 clocks per bit
// Notes: Crystal and clock pin inputs idle; internal rate used throughout
`timescale 1ns/1ps
`default_nettype none
`include "acia_params.svh"
module acia_txrx_tb;
   logic sys_clk_i = 1'b0, arst_n_i = 1'b0, cs_i = 1'b0, rw_i = 1'b1;
   logic [1:0] rs_i = 2'h0;
   logic [7:0] data_i = 8'h00, data_o, s;
   logic data_oe_n_o, irq_n_o, txd_o, rxd, rts_n_o, dtr_n_o, rxc_o, rxc_oe_n_o, ok;
   logic cts_n = 1'b0, dcd_n = 1'b1, dsr_n = 1'b1;
   logic [8:0] d;
   int err_total = 0, checks = 0, t, p;
   always #25 sys_clk_i = ~sys_clk_i;
   acia_txrx #(.VARIANT_A(1'b0), .BASE_DIV(8'h01)) i_acia_txrx (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
      .cs_i(cs_i), .rw_i(rw_i), .rs_i(rs_i), .data_i(data_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
      .irq_n_o(irq_n_o), .txd_o(txd_o), .rxd_i(rxd), .cts_n_i(cts_n), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
      .dcd_n_i(dcd_n), .dsr_n_i(dsr_n), .xtal_clk_i(1'b0), .rxc_i(1'b0), .rxc_o(rxc_o),
      .rxc_oe_n_o(rxc_oe_n_o));
   modem_model i_modem_model (.sys_clk_i(sys_clk_i), .txd_i(txd_o), .rxd_o(rxd));
   // ==========================================
   // Shared tasks
   task cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task wr(input logic [1:0] a, input logic [7:0] v);
      cs_i = 1'b1;
      rw_i = 1'b0;
      rs_i = a;
      data_i = v;
      cyc(1);
      cs_i = 1'b0;
      rw_i = 1'b1;
      cyc(1);
   endtask
   task rd(input logic [1:0] a, output logic [7:0] v);
      cs_i = 1'b1;
      rw_i = 1'b1;
      rs_i = a;
      cyc(1);
      cs_i = 1'b0;
      v = data_o;
      cyc(1);
   endtask
   task cmp(input logic [7:0] g, input logic [7:0] e, input string m);
      checks++;
      if (g !== e) begin
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
         err_total++;
      end
   endtask
   task conclude;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task wait_irq(input int n, output int c);
      c = 0;
      while (irq_n_o !== 1'b0 && c < n) begin
         cyc(1);
         c++;
      end
      if (c >= n) begin
         $display("CHECK FAILED t=%0t interrupt wait ran out", $time);
         err_total++;
         conclude();
      end
   endtask
   // ==========================================
   // Scenarios
   task get(input int nb);
      i_modem_model.grab(nb, d, ok);
      checks++;
      if (ok !== 1'b1) begin
         $display("CHECK FAILED t=%0t start bit wait ran out", $time);
         err_total++;
         conclude();
      end
   endtask
   task t_tx;
      wr(`RS_CMD, 8'h05);
      wr(`RS_DATA, 8'ha5);
      get(8);
      cmp(d[7:0], 8'ha5, "tx word");
      cmp(irq_n_o, 1'b0, "tx irq");
      rd(`RS_STAT, s);
      cmp(s & 8'h90, 8'h90, "tx status");
      rd(`RS_STAT, s);
      cmp(s & 8'h80, 8'h00, "irq bit cleared");
      wr(`RS_CMD, 8'h01);
      wr(`RS_CMD, 8'h09);
   endtask
   task t_parity;
      for (p = 0; p < 4; p++) begin
         wr(`RS_CMD, {p[1:0], 6'h29});
         wr(`RS_DATA, 8'h03);
         get(9);
         cmp(d[7:0], 8'h03, "parity data");
         cmp({7'h00, d[8]}, {7'h00, ~p[0]}, "parity bit");
         cyc(30);
      end
      wr(`RS_CMD, 8'h09);
   endtask
   task t_rx;
      fork
         i_modem_model.send(8'h3c, 1'b1);
         wait_irq(400, t);
      join
      cmp(t >= 148 && t <= 160, 1'b1, "rx irq time");
      rd(`RS_STAT, s);
      cmp(s & 8'h8f, 8'h88, "rx status");
      rd(`RS_DATA, s);
      cmp(s, 8'h3c, "rx data");
      rd(`RS_STAT, s);
      cmp(s & 8'h08, 8'h00, "full cleared");
   endtask
   task t_ovr;
      i_modem_model.send(8'h11, 1'b1);
      i_modem_model.send(8'h22, 1'b0);
      rd(`RS_STAT, s);
      cmp(s & 8'h0f, 8'h0e, "overrun framing");
      rd(`RS_DATA, s);
      cmp(s, 8'h11, "kept word");
      i_modem_model.send(8'h33, 1'b1);
      rd(`RS_STAT, s);
      cmp(s & 8'h0f, 8'h08, "flags per word");
      rd(`RS_DATA, s);
      cmp(s, 8'h33, "next word");
   endtask
   task t_rxoff;
      wr(`RS_CMD, 8'h0b);
      i_modem_model.send(8'h44, 1'b1);
      cmp(irq_n_o, 1'b1, "rx irq masked");
      rd(`RS_STAT, s);
      cmp(s & 8'h88, 8'h08, "masked status");
      rd(`RS_DATA, s);
      wr(`RS_CMD, 8'h09);
   endtask
   task t_echo;
      wr(`RS_CMD, 8'h11);
      fork
         i_modem_model.send(8'h96, 1'b1);
         get(8);
      join
      cmp(d[7:0], 8'h96, "echo word");
      // Data still unread, so this word overruns and blocks the echo
      i_modem_model.send(8'h69, 1'b1);
      fork
         i_modem_model.send(8'h5a, 1'b1);
         begin
            cyc(12);
            cmp(txd_o, 1'b1, "echo held after overrun");
         end
      join
      rd(`RS_DATA, s);
      cmp(s, 8'h96, "echo kept word");
      fork
         i_modem_model.send(8'h3c, 1'b1);
         get(8);
      join
      cmp(d[7:0], 8'h3c, "echo resumes");
      rd(`RS_STAT, s);
      rd(`RS_DATA, s);
      wr(`RS_CMD, 8'h09);
   endtask
   task t_dcd;
      dcd_n = 1'b0;
      cyc(4);
      cmp(irq_n_o, 1'b0, "carrier irq");
      dcd_n = 1'b1;
      cyc(4);
      rd(`RS_STAT, s);
      cmp(s & 8'ha0, 8'ha0, "carrier frozen");
      cyc(4);
      cmp(irq_n_o, 1'b0, "carrier re-irq");
      rd(`RS_STAT, s);
      cmp(s & 8'ha0, 8'h80, "carrier resampled");
   endtask
   task t_cts_brk;
      cts_n = 1'b1;
      wr(`RS_DATA, 8'h5a);
      cyc(200);
      cmp(txd_o, 1'b1, "cts mark");
      rd(`RS_STAT, s);
      cmp(s & 8'h10, 8'h00, "cts empty hidden");
      // Blocked frames keep their pace, so interrupts still arrive
      wr(`RS_CMD, 8'h05);
      cyc(170);
      cmp(irq_n_o, 1'b0, "irq while blocked");
      rd(`RS_STAT, s);
      cmp(s & 8'h90, 8'h80, "blocked irq status");
      wr(`RS_CMD, 8'h01);
      wr(`RS_CMD, 8'h09);
      cts_n = 1'b0;
      get(8);
      cmp(d[7:0], 8'h5a, "held word sent");
      cyc(30);
      wr(`RS_CMD, 8'h0d);
      cyc(40);
      cmp(txd_o, 1'b0, "break sent");
      wr(`RS_CMD, 8'h09);
      cyc(3);
      cmp(txd_o, 1'b1, "stop after break");
   endtask
   initial begin
      cyc(3);
      arst_n_i = 1'b1;
      cmp({txd_o, irq_n_o, dtr_n_o, rts_n_o, rxc_oe_n_o, data_oe_n_o}, 8'h3f, "reset pins");
      rd(`RS_STAT, s);
      cmp(s, 8'h10, "reset status");
      wr(`RS_CTRL, 8'h1f);
      wr(`RS_CMD, 8'h09);
      cyc(2);
      cmp({dtr_n_o, rts_n_o, rxc_oe_n_o, rxc_o}, 8'h01, "enabled pins");
      t_tx();
      t_parity();
      t_rx();
      t_ovr();
      t_rxoff();
      t_echo();
      t_dcd();
      t_cts_brk();
      conclude();
   end
endmodule // acia_txrx_tb
`default_nettype wire
